//--- shared/ulpi_regs_pkg.sv
// Shared constants for the transceiver register end and the link controller end.
// Assumes both ends run on one clock and meet through ulpi_link_if.
package ulpi_regs_pkg;
    // Six-bit register addresses seen on the link; set and clear aliases follow each base except the latch.
    localparam logic [5:0] ADDR_INTERFACE_CONTROL_REGISTER = 6'h07;
    localparam logic [5:0] ADDR_LATCH = 6'h14;
    localparam logic [5:0] ADDR_SCRATCH = 6'h16;
    localparam logic [5:0] ADDR_ROUTE = 6'h19;
    localparam logic [5:0] ADDR_PWR = 6'h3D;
    localparam logic [5:0] OFS_SET = 6'h01;
    localparam logic [5:0] OFS_CLR = 6'h02;
    // Field positions and implemented-bit masks.
    localparam int ROUTE_RX_BIT = 3;
    localparam int ROUTE_TX_BIT = 2;
    localparam int PWR_PULLUP_BIT = 4;
    localparam int PWR_FALL_BIT = 3;
    localparam int PWR_RISE_BIT = 2;
    localparam int INTF_UART_BIT = 3;
    localparam int LATCH_BVALID_BIT = 2;
    localparam int RXCMD_ALT_BIT = 7;
    localparam int RXCMD_BVALID_BIT = 3;
    localparam logic [7:0] ROUTE_MASK = 8'h0C;
    localparam logic [7:0] PWR_MASK = 8'h1C;
    localparam logic [7:0] INTF_MASK = 8'h08;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] ROUTE_ENTER = 8'h0C;
    localparam logic [7:0] UART_RX_LANE = 8'h02;
    localparam logic [7:0] UART_TX_LANE = 8'h01;
    localparam logic [7:0] ALL_LANES = 8'hFF;
    localparam logic [7:0] NO_LANES = 8'h00;
    // Command byte codes in bits 7:6.
    localparam logic [1:0] CMD_WRITE = 2'h2;
    localparam logic [1:0] CMD_READ = 2'h3;
    // Link controller APB map and fields.
    localparam logic [11:0] APB_CMD = 12'h000;
    localparam logic [11:0] APB_STATUS = 12'h004;
    localparam logic [11:0] APB_IRQ_STAT = 12'h008;
    localparam logic [11:0] APB_IRQ_CLR = 12'h00C;
    localparam logic [11:0] APB_IRQ_EN = 12'h010;
    localparam logic [11:0] APB_UART = 12'h014;
    localparam int CMD_READ_BIT = 16;
    localparam int CMD_ENTER_BIT = 17;
    localparam int CMD_EXIT_BIT = 18;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ALT_BIT = 1;
    localparam int IRQ_RXCMD_BIT = 2;
    localparam logic [1:0] SEQ_LAST = 2'h2;
endpackage

//--- shared/ulpi_link_if.sv
// Link wires between the transceiver end and the link controller end.
// Assumes one shared clock; the data bus level is resolved here from both enables.
interface ulpi_link_if;
    logic [7:0] link_dout;
    logic [7:0] link_oe;
    logic [7:0] phy_dout;
    logic [7:0] phy_oe;
    logic [7:0] data;
    logic dir;
    logic nxt;
    logic stp;

    // The transceiver wins a lane that both ends drive; undriven lanes read low.
    assign data = (phy_oe & phy_dout) | (~phy_oe & link_oe & link_dout);

    modport phy_end (input data, input stp, output phy_dout, output phy_oe, output dir, output nxt);
    modport link_end (input data, input dir, input nxt, output link_dout, output link_oe,
                      output stp);
endinterface

//--- hdl/ulpi_link_ctrl.sv
// Link controller end: APB command registers drive register and UART-mode transfers.
// Assumes the transceiver end on the other side of ulpi_link_if and the same pclk.
module ulpi_link_ctrl
    import ulpi_regs_pkg::*;
(
    // Clock, reset and clock enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt.
    output logic irq,
    // Link.
    ulpi_link_if.link_end bus
);
    typedef enum logic [2:0] {L_IDLE, L_CMD, L_DATA, L_RWAIT, L_STOP} link_state_t;

    link_state_t state_q;
    logic host_pend_q, seq_active_q, stop_pend_q, in_uart_q, is_read_q, uart_tx_q, host_read_q;
    logic [1:0] step_q;
    logic [5:0] host_addr_q, addr_q;
    logic [7:0] host_wdata_q, wdata_q, rdata_q, rxcmd_q;
    logic [2:0] irq_stat_q, irq_en_q;
    logic apb_wr, busy, launch, done, rx_seen, step_read;
    logic [5:0] step_addr;
    logic [7:0] step_wdata;
    logic [2:0] irq_set;

    // APB decode; every access completes in its first access cycle.
    assign apb_wr = psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign busy = (state_q != L_IDLE) | host_pend_q | seq_active_q | stop_pend_q;

    // Entry order: empty the event latch, select UART mode, then open both routes.
    assign step_read = (step_q == 2'h0);
    assign step_addr = (step_q == 2'h0) ? ADDR_LATCH :
                       (step_q == 2'h1) ? ADDR_INTERFACE_CONTROL_REGISTER + OFS_SET : ADDR_ROUTE;
    // Only implemented bits are ever written as ones.
    assign step_wdata = (step_q == 2'h1) ? INTF_MASK : ROUTE_ENTER;

    // A transfer starts only while the transceiver is not turning the bus around.
    assign launch = (state_q == L_IDLE) & ~stop_pend_q & (seq_active_q | host_pend_q) &
                    ~bus.dir & ~in_uart_q;
    assign done = ((state_q == L_DATA) & bus.nxt) | ((state_q == L_RWAIT) & bus.dir & bus.nxt);
    assign rx_seen = bus.dir & ~bus.nxt;

    // Bus drive: full byte for commands, only lane 0 while in UART mode.
    assign bus.link_oe = (state_q == L_CMD || state_q == L_DATA) ? ALL_LANES :
                         in_uart_q ? UART_TX_LANE : NO_LANES;
    assign bus.link_dout = (state_q == L_CMD) ? {(is_read_q ? CMD_READ : CMD_WRITE), addr_q} :
                           (state_q == L_DATA) ? wdata_q : {7'h00, uart_tx_q};
    assign bus.stp = (state_q == L_STOP);

    // Interrupt events; a new event beats a clear in the same cycle.
    assign irq_set = {rx_seen, rx_seen & bus.data[RXCMD_ALT_BIT], done | (state_q == L_STOP)};
    assign irq = |(irq_stat_q & irq_en_q);

    // APB read mux from flops, except the live link lane 1 level at the UART address.
    always_comb begin
        case (paddr)
            APB_STATUS: prdata = {8'h00, rxcmd_q, 6'h00, in_uart_q, busy, rdata_q};
            APB_IRQ_STAT: prdata = {29'h0, irq_stat_q};
            APB_IRQ_EN: prdata = {29'h0, irq_en_q};
            APB_UART: prdata = {30'h0, bus.data[1], uart_tx_q};
            default: prdata = 32'h0;
        endcase
    end

    // Software registers and command capture; commands written while busy are dropped.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= 3'h0;
            irq_en_q <= 3'h0;
            uart_tx_q <= 1'b1;
            host_pend_q <= 1'b0;
            stop_pend_q <= 1'b0;
            host_addr_q <= 6'h00;
            host_wdata_q <= 8'h00;
        end else if (clk_en) begin
            irq_stat_q <= irq_set | (irq_stat_q & ~((apb_wr && paddr == APB_IRQ_CLR) ?
                          pwdata[2:0] : 3'h0));
            if (apb_wr && paddr == APB_IRQ_EN) irq_en_q <= pwdata[2:0];
            if (apb_wr && paddr == APB_UART) uart_tx_q <= pwdata[0];
            if (launch && !seq_active_q) host_pend_q <= 1'b0;
            if (state_q == L_STOP) stop_pend_q <= 1'b0;
            if (apb_wr && paddr == APB_CMD && !busy) begin
                host_pend_q <= ~pwdata[CMD_EXIT_BIT] & ~pwdata[CMD_ENTER_BIT];
                stop_pend_q <= pwdata[CMD_EXIT_BIT];
                host_addr_q <= pwdata[13:8];
                host_wdata_q <= pwdata[7:0];
            end
        end
    end

    // Transfer engine and entry sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= L_IDLE;
            seq_active_q <= 1'b0;
            step_q <= 2'h0;
            in_uart_q <= 1'b0;
            is_read_q <= 1'b0;
            addr_q <= 6'h00;
            wdata_q <= 8'h00;
            rdata_q <= 8'h00;
            rxcmd_q <= 8'h00;
        end else if (clk_en) begin
            if (rx_seen) rxcmd_q <= bus.data;
            if (apb_wr && paddr == APB_CMD && !busy && pwdata[CMD_ENTER_BIT] &&
                !pwdata[CMD_EXIT_BIT]) begin
                seq_active_q <= 1'b1;
                step_q <= 2'h0;
            end
            if (done && seq_active_q) begin
                step_q <= step_q + 2'h1;
                if (step_q == SEQ_LAST) begin
                    seq_active_q <= 1'b0;
                    in_uart_q <= 1'b1;
                end
            end
            case (state_q)
                L_IDLE: begin
                    if (stop_pend_q) begin
                        state_q <= L_STOP;
                    end else if (launch) begin
                        state_q <= L_CMD;
                        is_read_q <= seq_active_q ? step_read : host_read_q;
                        addr_q <= seq_active_q ? step_addr : host_addr_q;
                        wdata_q <= seq_active_q ? step_wdata : host_wdata_q;
                    end
                end
                L_CMD: if (bus.nxt) state_q <= is_read_q ? L_RWAIT : L_DATA;
                L_DATA: if (bus.nxt) state_q <= L_IDLE;
                L_RWAIT: begin
                    if (bus.dir && bus.nxt) begin
                        rdata_q <= bus.data;
                        state_q <= L_IDLE;
                    end
                end
                L_STOP: begin
                    in_uart_q <= 1'b0;
                    state_q <= L_IDLE;
                end
                default: state_q <= L_IDLE;
            endcase
        end
    end

    // Host command direction bit, held beside the captured address.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_read_q <= 1'b0;
        end else if (clk_en && apb_wr && paddr == APB_CMD && !busy) begin
            host_read_q <= pwdata[CMD_READ_BIT];
        end
    end
endmodule

//--- hdl/ulpi_phy_uart_power_regs.sv
// Transceiver end: test byte, UART routing, power feature and a small event latch.
// Assumes the link controller end on ulpi_link_if; analog pins arrive unsynchronised.
//
// Local design decision: the APB interface to the registers.

module ulpi_phy_uart_power_regs
    import ulpi_regs_pkg::*;
(
    // Clock, reset and clock enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Link.
    ulpi_link_if.phy_end bus,
    // Pins from outside the clock domain.
    input wire logic chip_sel_n,
    input wire logic dplus_level,
    input wire logic vbus_above_asess,
    input wire logic bvalid,
    // Analog controls.
    output logic dminus_drive,
    output logic dminus_oe,
    output logic dplus_weak_pullup_on,
    output logic uart_mode
);
    typedef enum logic [1:0] {ST_IDLE, ST_WDATA, ST_RDATA, ST_RXCMD} phy_state_t;

    phy_state_t state_q;
    logic [3:0] sync1_q, sync2_q;
    logic bvalid_prev_q, uart_q, pend_q, dm_q, pullup_q;
    logic [5:0] addr_q;
    logic [7:0] scratch_q, route_q, pwr_q, intf_q, latch_q, dout_q;
    logic cs_off, dp_sync, vbus_sync, bv_sync, bv_rise, bv_fall, bv_event;
    logic [1:0] cmd_code;
    logic [5:0] cmd_addr;
    logic cmd_seen, cmd_is_read, wr_fire, exit_now, enter_now, pend_set, latch_read;
    logic [2:0] scr_op, route_op, pwr_op, intf_op;
    logic [7:0] scratch_d, route_d, pwr_d, intf_d, latch_d, rd_val, rxcmd_byte;

    // One-hot {clear, set, write} hit for a register group at base.
    function automatic logic [2:0] op_hit(input logic [5:0] a, input logic [5:0] base);
        op_hit = {a == base + OFS_CLR, a == base + OFS_SET, a == base};
    endfunction

    // Direct write, set ones, or clear ones.
    function automatic logic [7:0] apply(input logic [7:0] cur, input logic [7:0] wv,
                                         input logic [2:0] op);
        apply = op[0] ? wv : op[1] ? (cur | wv) : op[2] ? (cur & ~wv) : cur;
    endfunction

    // Named views of the synchronised pins.
    assign cs_off = sync2_q[3];
    assign dp_sync = sync2_q[2];
    assign vbus_sync = sync2_q[1];
    assign bv_sync = sync2_q[0];
    assign bv_rise = bv_sync & ~bvalid_prev_q;
    assign bv_fall = ~bv_sync & bvalid_prev_q;
    assign bv_event = bv_rise | bv_fall;

    // Command recognition; in UART mode the link bus carries UART levels, not commands.
    assign cmd_code = bus.data[7:6];
    assign cmd_addr = bus.data[5:0];
    assign cmd_is_read = (cmd_code == CMD_READ);
    assign cmd_seen = (state_q == ST_IDLE) & ~uart_q &
                      ((cmd_code == CMD_WRITE) | cmd_is_read);
    assign latch_read = cmd_seen & cmd_is_read & (cmd_addr == ADDR_LATCH);
    assign bus.nxt = cmd_seen | (state_q == ST_WDATA) | (state_q == ST_RDATA);
    assign bus.dir = (state_q == ST_RDATA) | (state_q == ST_RXCMD);

    // Write decode; data is taken in the cycle after the command byte.
    assign wr_fire = (state_q == ST_WDATA);
    assign scr_op = wr_fire ? op_hit(addr_q, ADDR_SCRATCH) : 3'h0;
    assign route_op = wr_fire ? op_hit(addr_q, ADDR_ROUTE) : 3'h0;
    assign pwr_op = wr_fire ? op_hit(addr_q, ADDR_PWR) : 3'h0;
    assign intf_op = wr_fire ? op_hit(addr_q, ADDR_INTERFACE_CONTROL_REGISTER) : 3'h0;

    // UART entry needs the select bit and both routes; exit by stop or deselect.
    assign enter_now = intf_q[INTF_UART_BIT] & route_q[ROUTE_RX_BIT] &
                       route_q[ROUTE_TX_BIT] & ~uart_q;
    assign exit_now = uart_q & bus.stp;

    // Next register values; only implemented bits are stored, the rest read zero.
    assign scratch_d = apply(scratch_q, bus.data, scr_op);
    assign route_d = exit_now ? REG_RESET : (apply(route_q, bus.data, route_op) & ROUTE_MASK);
    assign intf_d = exit_now ? REG_RESET : (apply(intf_q, bus.data, intf_op) & INTF_MASK);
    assign pwr_d = apply(pwr_q, bus.data, pwr_op) & PWR_MASK;

    // Latch: a new edge beats the clear by read or by UART entry.
    assign latch_d = ((latch_read | enter_now) ? REG_RESET : latch_q) |
                     (bv_event ? (8'h01 << LATCH_BVALID_BIT) : REG_RESET);

    // Alternate event request; a fresh edge beats the clear when one is sent.
    assign pend_set = (bv_fall & pwr_q[PWR_FALL_BIT]) |
                      (bv_rise & pwr_q[PWR_RISE_BIT]);

    // Event byte: alternate flag always set, current B-valid beside it.
    assign rxcmd_byte = (8'h01 << RXCMD_ALT_BIT) |
                        (bv_sync ? (8'h01 << RXCMD_BVALID_BIT) : REG_RESET);

    // Read mux; each register except the latch answers at all three of its addresses; the latch answers only at its base.
    assign rd_val = (|op_hit(cmd_addr, ADDR_SCRATCH)) ? scratch_q :
                    (|op_hit(cmd_addr, ADDR_ROUTE)) ? route_q :
                    (|op_hit(cmd_addr, ADDR_PWR)) ? pwr_q :
                    (|op_hit(cmd_addr, ADDR_INTERFACE_CONTROL_REGISTER)) ? intf_q :
                    (cmd_addr == ADDR_LATCH) ? latch_q : REG_RESET;

    // Bus drive: full byte when turned around, else lane 1 only for the UART receive path.
    assign bus.phy_oe = bus.dir ? ALL_LANES :
                        (uart_q & route_q[ROUTE_RX_BIT]) ? UART_RX_LANE : NO_LANES;
    assign bus.phy_dout = bus.dir ? dout_q : {6'h00, dp_sync, 1'b0};

    // Analog side; the transmit path only drives while its route is open in UART mode.
    assign dminus_drive = dm_q;
    assign dminus_oe = uart_q & route_q[ROUTE_TX_BIT];
    assign dplus_weak_pullup_on = pullup_q;
    assign uart_mode = uart_q;

    // Two-stage synchronisers; only the second stage feeds logic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            bvalid_prev_q <= 1'b0;
        end else if (clk_en) begin
            sync1_q <= {chip_sel_n, dplus_level, vbus_above_asess, bvalid};
            sync2_q <= sync1_q;
            bvalid_prev_q <= bv_sync;
        end
    end

    // Registers; a deselected chip returns them all to reset, which also ends UART mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scratch_q <= REG_RESET;
            route_q <= REG_RESET;
            pwr_q <= REG_RESET;
            intf_q <= REG_RESET;
            latch_q <= REG_RESET;
            uart_q <= 1'b0;
        end else if (clk_en) begin
            if (cs_off) begin
                scratch_q <= REG_RESET;
                route_q <= REG_RESET;
                pwr_q <= REG_RESET;
                intf_q <= REG_RESET;
                latch_q <= REG_RESET;
                uart_q <= 1'b0;
            end else begin
                scratch_q <= scratch_d;
                route_q <= route_d;
                pwr_q <= pwr_d;
                intf_q <= intf_d;
                latch_q <= latch_d;
                uart_q <= (uart_q & ~exit_now) | enter_now;
            end
        end
    end

    // Analog outputs from flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dm_q <= 1'b1;
            pullup_q <= 1'b0;
        end else if (clk_en) begin
            dm_q <= bus.data[0];
            pullup_q <= uart_q | (pwr_q[PWR_PULLUP_BIT] & vbus_sync);
        end
    end

    // Link state machine; a link command in the same cycle wins over a pending event byte.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            addr_q <= 6'h00;
            dout_q <= REG_RESET;
            pend_q <= 1'b0;
        end else if (clk_en) begin
            pend_q <= pend_set | (pend_q & ~(state_q == ST_RXCMD) & ~cs_off);
            case (state_q)
                ST_IDLE: begin
                    if (cmd_seen) begin
                        addr_q <= cmd_addr;
                        dout_q <= rd_val;
                        state_q <= cmd_is_read ? ST_RDATA : ST_WDATA;
                    end else if (pend_q && !uart_q && !cs_off) begin
                        dout_q <= rxcmd_byte;
                        state_q <= ST_RXCMD;
                    end
                end
                ST_WDATA: state_q <= ST_IDLE;
                ST_RDATA: state_q <= ST_IDLE;
                ST_RXCMD: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

//--- sim/ulpi_link_assertions.sv
// Checker for the link wires and pins of the transceiver register end.
// Assumes one clock; the bench instantiates it beside the link interface.
module ulpi_link_assertions
    import ulpi_regs_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Link wires and transceiver pins.
    input wire logic [7:0] data,
    input wire logic dir,
    input wire logic nxt,
    input wire logic stp,
    input wire logic uart_mode,
    input wire logic dminus_oe,
    input wire logic dminus_drive,
    input wire logic dplus_weak_pullup_on
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A fresh command is the first accepted cycle after a quiet one, so data bytes never match.
    sequence s_new_cmd(logic [1:0] code);
        nxt && !$past(nxt) && !dir && data[7:6] == code;
    endsequence
    sequence s_data_phase;
        nxt && !dir ##1 !nxt;
    endsequence

    a_write_data_phase: assert property (s_new_cmd(CMD_WRITE) |=> s_data_phase)
        else $error("write command not followed by one data cycle");
    a_read_answer: assert property (s_new_cmd(CMD_READ) |=> dir && nxt)
        else $error("read command not answered next cycle");
    a_event_alt_flag: assert property (dir && !nxt |-> data[RXCMD_ALT_BIT])
        else $error("event byte without alternate flag");
    a_uart_no_accept: assert property (uart_mode |-> !nxt)
        else $error("command accepted in UART mode");
    a_stop_exits_uart: assert property (stp && uart_mode |=> !uart_mode && !dminus_oe)
        else $error("stop did not leave UART mode");
    a_stop_one_cycle: assert property (stp |=> !stp)
        else $error("stop longer than one cycle");
    a_pullup_in_uart: assert property (uart_mode ##1 uart_mode |-> dplus_weak_pullup_on)
        else $error("weak pull-up off in UART mode");
    a_tx_gated: assert property (dminus_oe |-> uart_mode)
        else $error("D- driven outside UART mode");
    a_tx_follows_lane: assert property (dminus_oe ##1 dminus_oe |-> dminus_drive == $past(data[0]))
        else $error("D- does not follow lane 0");
    a_pullup_reset: assert property ($rose(presetn) |-> !dplus_weak_pullup_on)
        else $error("weak pull-up on after reset");
endmodule

//--- sim/tb_top.sv
// Bench joining both ends over the link; APB tasks drive the link controller.
// Assumes pready and busy come back on their own; a cycle ceiling ends a hang.
module tb_top
    import ulpi_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, irq, dminus_drive, dminus_oe, dplus_weak_pullup_on, uart_mode;
    logic chip_sel_n = 1'b0, dplus_level = 1'b0, vbus_above_asess = 1'b0, bvalid = 1'b0;
    int miscompares = 0, compares = 0, cycles = 0;
    `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
        $display("mismatch %s exp %0h got %0h", n, e, g); end end

    ulpi_link_if link_if ();
    ulpi_phy_uart_power_regs ulpi_phy_uart_power_regs_inst (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .bus(link_if), .chip_sel_n(chip_sel_n), .dplus_level(dplus_level),
        .vbus_above_asess(vbus_above_asess), .bvalid(bvalid), .dminus_drive(dminus_drive),
        .dminus_oe(dminus_oe), .dplus_weak_pullup_on(dplus_weak_pullup_on),
        .uart_mode(uart_mode));
    ulpi_link_ctrl ulpi_link_ctrl_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .bus(link_if));
    ulpi_link_assertions chk_inst (.pclk(pclk), .presetn(presetn), .data(link_if.data),
        .dir(link_if.dir), .nxt(link_if.nxt), .stp(link_if.stp), .uart_mode(uart_mode),
        .dminus_oe(dminus_oe), .dminus_drive(dminus_drive),
        .dplus_weak_pullup_on(dplus_weak_pullup_on));

    // Free-running clock and a ceiling well above the few hundred cycles the run needs.
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One APB transfer; read data lands in rd at the edge that samples pready.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        `CHK("pslverr", 1'b0, pslverr)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Issue a link command and poll until busy drops; rd then holds the last status.
    task automatic phy_cmd(input logic [31:0] c);
        apb(1'b1, APB_CMD, c);
        do apb(1'b0, APB_STATUS, 32'h0); while (rd[8] !== 1'b0);
    endtask

    task automatic phy_wr(input logic [5:0] a, input logic [7:0] v);
        phy_cmd({18'h0, a, v});
    endtask

    task automatic rd_chk(input string n, input logic [5:0] a, input logic [7:0] e);
        phy_cmd({15'h0, 1'b1, 2'b00, a, 8'h00});
        `CHK(n, e, rd[7:0])
    endtask

    // Moves bvalid, then judges the event flag, the interrupt line and the clear.
    task automatic edge_chk(input logic lvl, input logic alt, input logic int_on);
        @(posedge pclk);
        bvalid <= lvl;
        repeat (12) @(posedge pclk);
        apb(1'b0, APB_IRQ_STAT, 32'h0);
        `CHK("alt event", alt, rd[IRQ_ALT_BIT])
        `CHK("irq", int_on, irq)
        if (alt) begin
            apb(1'b0, APB_STATUS, 32'h0);
            `CHK("event level", lvl, rd[16 + RXCMD_BVALID_BIT])
        end
        apb(1'b1, APB_IRQ_CLR, 32'h0000_0007);
        @(posedge pclk);
        `CHK("irq clear", 1'b0, irq)
    endtask

    task automatic t_regs();
        rd_chk("scratch reset", ADDR_SCRATCH, 8'h00);
        rd_chk("power reset", ADDR_PWR, 8'h00);
        apb(1'b0, 12'h020, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        phy_wr(ADDR_SCRATCH, 8'hA5);
        rd_chk("scratch", ADDR_SCRATCH, 8'hA5);
        phy_wr(ADDR_SCRATCH + OFS_SET, 8'h50);
        rd_chk("scratch set", ADDR_SCRATCH + OFS_SET, 8'hF5);
        phy_wr(ADDR_SCRATCH + OFS_CLR, 8'h05);
        rd_chk("scratch clr", ADDR_SCRATCH + OFS_CLR, 8'hF0);
        rd_chk("route untouched", ADDR_ROUTE, 8'h00);
    endtask

    task automatic t_power();
        vbus_above_asess <= 1'b1;
        phy_wr(ADDR_PWR, 8'h14);
        rd_chk("power", ADDR_PWR, 8'h14);
        phy_wr(ADDR_PWR + OFS_SET, 8'h08);
        rd_chk("power set", ADDR_PWR + OFS_SET, 8'h1C);
        `CHK("pullup on", 1'b1, dplus_weak_pullup_on)
        phy_wr(ADDR_PWR + OFS_CLR, 8'h10);
        rd_chk("power clr", ADDR_PWR + OFS_CLR, 8'h0C);
        `CHK("pullup off", 1'b0, dplus_weak_pullup_on)
        vbus_above_asess <= 1'b0;
        phy_wr(ADDR_PWR, 8'h10);
        repeat (8) @(posedge pclk);
        `CHK("pullup no vbus", 1'b0, dplus_weak_pullup_on)
    endtask

    task automatic t_events();
        phy_wr(ADDR_PWR, 8'h04);
        apb(1'b1, APB_IRQ_EN, 32'h0000_0002);
        apb(1'b1, APB_IRQ_CLR, 32'h0000_0007);
        edge_chk(1'b1, 1'b1, 1'b1);
        edge_chk(1'b0, 1'b0, 1'b0);
        phy_wr(ADDR_PWR, 8'h08);
        edge_chk(1'b1, 1'b0, 1'b0);
        apb(1'b1, APB_IRQ_EN, 32'h0);
        edge_chk(1'b0, 1'b1, 1'b0);
        // Every edge above latched the event bit; a read must empty the latch.
        rd_chk("latch", ADDR_LATCH, 8'h01 << LATCH_BVALID_BIT);
        rd_chk("latch cleared", ADDR_LATCH, 8'h00);
        phy_wr(ADDR_PWR, 8'h00);
    endtask

    task automatic t_uart();
        phy_wr(ADDR_ROUTE + OFS_SET, ROUTE_ENTER);
        rd_chk("route set", ADDR_ROUTE + OFS_CLR, ROUTE_ENTER);
        `CHK("no select", 1'b0, uart_mode | dminus_oe)
        phy_wr(ADDR_ROUTE + OFS_CLR, ROUTE_ENTER);
        rd_chk("route clr", ADDR_ROUTE, 8'h00);
        apb(1'b1, APB_UART, 32'h1);
        phy_cmd(32'h1 << CMD_ENTER_BIT);
        repeat (2) @(posedge pclk);
        `CHK("enter", 3'b111, {uart_mode, dminus_oe, rd[9]})
        `CHK("uart pullup", 1'b1, dplus_weak_pullup_on)
        apb(1'b1, APB_UART, 32'h0);
        repeat (3) @(posedge pclk);
        `CHK("tx low", 1'b0, dminus_drive)
        dplus_level <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, APB_UART, 32'h0);
        `CHK("rx high", 1'b1, rd[1])
        phy_cmd(32'h1 << CMD_EXIT_BIT);
        `CHK("exit", 2'b00, {uart_mode, rd[9]})
        rd_chk("routes cleared", ADDR_ROUTE, 8'h00);
        rd_chk("select cleared", ADDR_INTERFACE_CONTROL_REGISTER, 8'h00);
        phy_wr(ADDR_SCRATCH, 8'h3C);
        phy_cmd(32'h1 << CMD_ENTER_BIT);
        chip_sel_n <= 1'b1;
        repeat (6) @(posedge pclk);
        chip_sel_n <= 1'b0;
        repeat (6) @(posedge pclk);
        `CHK("deselect exit", 1'b0, uart_mode)
        phy_cmd(32'h1 << CMD_EXIT_BIT);
        rd_chk("scratch deselect", ADDR_SCRATCH, 8'h00);
    endtask

    // Reset for ten cycles, then the scenarios in order.
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_power();
        t_events();
        t_uart();
        test_done();
    end
endmodule
